/* hw/mise_pkg.sv */
// package of constants and types for the instruction subset execution block
package mise_pkg;
  // data and index widths
  localparam int DATA_W = 8;
  localparam int PAGE_IDX_W = 4;
  localparam int REG_ADDR_W = 6;
  localparam int PAGE_DEPTH = 16;
  // wishbone register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OPND = 8'h04;
  localparam logic [7:0] OFS_ACCUM = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  localparam logic [7:0] OFS_RES = 8'h14;
  // control word field positions
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_DEST_BIT = 4;
  localparam int CTRL_IDX_LSB = 8;
  localparam int CTRL_GO_BIT = 31;
  // status word field positions
  localparam int STAT_C_BIT = 0;
  localparam int STAT_DIGIT_BIT = 1;
  localparam int STAT_Z_BIT = 2;
  localparam int STAT_PWRDN_BIT = 3;
  localparam int STAT_TMOUT_BIT = 4;
  localparam int STAT_HALT_BIT = 5;
  localparam int STAT_WRREG_BIT = 6;
  // reset values
  localparam logic [7:0] ACCUM_RST = 8'h00;
  localparam logic [7:0] WATCHDOG_CLEAR = 8'h00;
  localparam logic FLAG_N_RST = 1'b1;
  // operations
  typedef enum logic [2:0] {
    MISE_OP_NONE = 3'h0,
    MISE_OP_SBCI = 3'h1,
    MISE_OP_PGRD = 3'h2,
    MISE_OP_PGWR = 3'h3,
    MISE_OP_SUBR = 3'h4,
    MISE_OP_SWAP = 3'h5,
    MISE_OP_HALT = 3'h6
  } mise_op_t;
  // bus slave state, gray along idle -> ack
  typedef enum logic [1:0] {
    MISE_ST_IDLE = 2'b00,
    MISE_ST_ACK = 2'b01
  } mise_st_t;
endpackage

/* hw/mise_page_mem.sv */
// sixteen entry special page register memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module mise_page_mem (
  // clock
  input wire logic clk_i,
  // write port
  input wire logic we_i,
  input wire logic [3:0] waddr_i,
  input wire logic [7:0] wdata_i,
  // read port
  input wire logic [3:0] raddr_i,
  output logic [7:0] rdata_o
);
  // storage array
  logic [7:0] mem_reg [mise_pkg::PAGE_DEPTH];

  // write and registered read
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_reg[raddr_i];
  end
endmodule
`default_nettype wire

/* hw/mise_exec.sv */
// execution unit for a subset of an 8-bit controller instruction set
//
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module mise_exec (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // halt and watchdog clear towards the core
  output logic halt_o,
  output logic watchdog_clear_o,
  // data register write back
  output logic reg_we_o,
  output logic [5:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  // architectural state
  logic [7:0] accumulator_reg;
  logic carry_reg, digit_carry_flag_reg, zero_reg;
  logic timeout_flag_n_reg, powerdown_flag_n_reg, halt_reg;
  logic [31:0] ctrl_reg;
  logic [7:0] opnd_reg, result_reg;
  logic [31:0] rdat_reg;
  logic ack_reg, watchdog_clear_reg, reg_we_reg;
  mise_pkg::mise_st_t st_reg;
  logic page_rd_pend_reg;
  logic [7:0] page_rdata;
  // last instruction wrote back to the data register
  logic to_reg_last;

  // bus decode
  wire req = wb_cyc_i & wb_stb_i & (st_reg == mise_pkg::MISE_ST_IDLE);
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire wr_ctrl = wr & (wb_adr_i == mise_pkg::OFS_CTRL);
  wire wr_opnd = wr & (wb_adr_i == mise_pkg::OFS_OPND);
  wire wr_accum = wr & (wb_adr_i == mise_pkg::OFS_ACCUM);
  wire wr_stat = wr & (wb_adr_i == mise_pkg::OFS_STAT);
  // instruction issue: write of control word with go bit
  wire go = wr_ctrl & wb_dat_i[mise_pkg::CTRL_GO_BIT];
  wire [2:0] op_raw = wb_dat_i[mise_pkg::CTRL_OP_LSB +: 3];
  wire dest_r = wb_dat_i[mise_pkg::CTRL_DEST_BIT];
  wire [5:0] idx = wb_dat_i[mise_pkg::CTRL_IDX_LSB +: 6];
  wire is_sbci = go & (op_raw == mise_pkg::MISE_OP_SBCI);
  wire is_pgrd = go & (op_raw == mise_pkg::MISE_OP_PGRD);
  wire is_pgwr = go & (op_raw == mise_pkg::MISE_OP_PGWR);
  wire is_subr = go & (op_raw == mise_pkg::MISE_OP_SUBR);
  wire is_swap = go & (op_raw == mise_pkg::MISE_OP_SWAP);
  wire is_halt = go & (op_raw == mise_pkg::MISE_OP_HALT);

  // adder: a + ~accumulator + cin, shared by both subtracts
  wire cin = is_sbci ? carry_reg : 1'b1;
  wire [4:0] lo_sum = {1'b0, opnd_reg[3:0]} + {1'b0, ~accumulator_reg[3:0]} + {4'h0, cin};
  wire [4:0] hi_sum = {1'b0, opnd_reg[7:4]} + {1'b0, ~accumulator_reg[7:4]} + {4'h0, lo_sum[4]};
  wire [7:0] diff = {hi_sum[3:0], lo_sum[3:0]};
  wire [7:0] swapped = {opnd_reg[3:0], opnd_reg[7:4]};
  wire [7:0] alu_res = is_swap ? swapped : diff;
  wire to_reg = (is_subr | is_swap) & dest_r;
  wire to_accum = is_sbci | ((is_subr | is_swap) & ~dest_r);
  wire sets_flags = is_sbci | is_subr;

  // read mux
  wire [31:0] stat_word = {25'h0, to_reg_last, halt_reg, timeout_flag_n_reg,
                           powerdown_flag_n_reg, zero_reg, digit_carry_flag_reg, carry_reg};
  wire [31:0] rd_mux =
    (wb_adr_i == mise_pkg::OFS_CTRL) ? ctrl_reg :
    (wb_adr_i == mise_pkg::OFS_OPND) ? {24'h0, opnd_reg} :
    (wb_adr_i == mise_pkg::OFS_ACCUM) ? {24'h0, accumulator_reg} :
    (wb_adr_i == mise_pkg::OFS_STAT) ? stat_word :
    (wb_adr_i == mise_pkg::OFS_RDATA) ? {24'h0, page_rdata} :
    (wb_adr_i == mise_pkg::OFS_RES) ? {24'h0, result_reg} : 32'h0;

  // special page register memory
  mise_page_mem i_mise_page_mem (
    .clk_i(clk_i),
    .we_i(is_pgwr),
    .waddr_i(idx[3:0]),
    .wdata_i(accumulator_reg),
    .raddr_i(idx[3:0]),
    .rdata_o(page_rdata)
  );

  // bus handshake: one wait state, ack for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= mise_pkg::MISE_ST_IDLE;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      ack_reg <= req;
      rdat_reg <= rd_mux;
      st_reg <= req ? mise_pkg::MISE_ST_ACK : mise_pkg::MISE_ST_IDLE;
    end
  end

  // instruction execution
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accumulator_reg <= mise_pkg::ACCUM_RST;
      carry_reg <= 1'b0;
      digit_carry_flag_reg <= 1'b0;
      zero_reg <= 1'b0;
      timeout_flag_n_reg <= mise_pkg::FLAG_N_RST;
      powerdown_flag_n_reg <= mise_pkg::FLAG_N_RST;
      halt_reg <= 1'b0;
      ctrl_reg <= 32'h0;
      opnd_reg <= 8'h00;
      result_reg <= 8'h00;
      watchdog_clear_reg <= 1'b0;
      reg_we_reg <= 1'b0;
      page_rd_pend_reg <= 1'b0;
      to_reg_last <= 1'b0;
      reg_addr_o <= 6'h00;
      reg_wdata_o <= 8'h00;
    end else begin
      watchdog_clear_reg <= is_halt;
      reg_we_reg <= to_reg;
      page_rd_pend_reg <= is_pgrd;
      if (wr_ctrl) begin
        ctrl_reg <= {1'b0, wb_dat_i[30:0]};
      end
      if (wr_opnd) begin
        opnd_reg <= wb_dat_i[7:0];
      end
      // status write lets software set flags and leave halt
      if (wr_stat) begin
        carry_reg <= wb_dat_i[mise_pkg::STAT_C_BIT];
        digit_carry_flag_reg <= wb_dat_i[mise_pkg::STAT_DIGIT_BIT];
        zero_reg <= wb_dat_i[mise_pkg::STAT_Z_BIT];
        halt_reg <= wb_dat_i[mise_pkg::STAT_HALT_BIT];
      end
      if (wr_accum) begin
        accumulator_reg <= wb_dat_i[7:0];
      end else if (to_accum) begin
        accumulator_reg <= alu_res;
      end else if (page_rd_pend_reg) begin
        accumulator_reg <= page_rdata;
      end
      if (sets_flags) begin
        carry_reg <= hi_sum[4];
        digit_carry_flag_reg <= lo_sum[4];
        zero_reg <= (diff == 8'h00);
      end
      if (go) begin
        result_reg <= alu_res;
        to_reg_last <= to_reg;
      end
      if (to_reg) begin
        reg_addr_o <= idx;
        reg_wdata_o <= alu_res;
      end
      if (is_halt) begin
        timeout_flag_n_reg <= 1'b1;
        powerdown_flag_n_reg <= 1'b0;
        halt_reg <= 1'b1;
      end
    end
  end

  // outputs
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign halt_o = halt_reg;
  assign watchdog_clear_o = watchdog_clear_reg;
  assign reg_we_o = reg_we_reg;

  // checks
  sbc_result_a: assert property (@(posedge clk_i) disable iff (rst_i)
    is_sbci |=> accumulator_reg == 8'($past(opnd_reg) + ~$past(accumulator_reg) + {7'h0, $past(carry_reg)}))
    else $error("immediate subtract result wrong");
  sbc_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    is_sbci |=> zero_reg == (accumulator_reg == 8'h00))
    else $error("zero flag wrong after immediate subtract");
  page_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    is_pgrd ##1 !wr_accum && !to_accum |=> accumulator_reg == $past(page_rdata))
    else $error("page read did not load accumulator");
  page_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    is_pgwr |=> $stable(accumulator_reg))
    else $error("page write changed accumulator");
  halt_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    is_halt |=> watchdog_clear_o && halt_o ##1 !watchdog_clear_o)
    else $error("halt entry did not clear watchdog");
  halt_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
    is_halt |=> timeout_flag_n_reg && !powerdown_flag_n_reg)
    else $error("halt flags wrong");
  sub_carry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    is_subr |=> carry_reg == ($past(opnd_reg) >= $past(accumulator_reg)))
    else $error("carry wrong after register subtract");
  dest_reg_a: assert property (@(posedge clk_i) disable iff (rst_i)
    to_reg |=> reg_we_o && $stable(accumulator_reg) ##1 !reg_we_o || to_reg)
    else $error("register destination not honoured");
  swap_value_a: assert property (@(posedge clk_i) disable iff (rst_i)
    is_swap && !dest_r |=> accumulator_reg == {$past(opnd_reg[3:0]), $past(opnd_reg[7:4])})
    else $error("nibble exchange wrong");
  flags_kept_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (is_pgrd || is_pgwr || is_swap) |=> $stable({carry_reg, digit_carry_flag_reg, zero_reg}))
    else $error("flags changed by flagless instruction");
  // digit carry is the carry out of the low nibble sum
  sbc_digit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    is_sbci |=> digit_carry_flag_reg == (({1'b0, $past(opnd_reg[3:0])} + {1'b0, ~$past(accumulator_reg[3:0])}
      + {4'h0, $past(carry_reg)}) > 5'h0F))
    else $error("digit carry wrong after immediate subtract");
  // zero flag follows the result even when it goes to the register
  sub_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    is_subr |=> zero_reg == (result_reg == 8'h00))
    else $error("zero flag wrong after register subtract");
  // swapped value is what the register write back carries
  swap_reg_a: assert property (@(posedge clk_i) disable iff (rst_i)
    is_swap && dest_r |=> reg_we_o && reg_wdata_o == {$past(opnd_reg[3:0]), $past(opnd_reg[7:4])})
    else $error("nibble exchange write back wrong");
endmodule
`default_nettype wire

/* dv/mise_exec_bench.sv */
// self-checking bench for the instruction subset execution block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module mise_exec_bench;
  // clock, reset and bus drive
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0000_0000;
  // design outputs
  logic [31:0] rdat;
  logic ack;
  logic halt;
  logic watchdog_clear;
  logic reg_we;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata;
  // counters and last read word
  int errors = 0;
  int checked = 0;
  int we_cnt = 0;
  int clr_cnt = 0;
  logic [31:0] rd;
  mise_exec i_mise_exec (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .halt_o(halt),
    .watchdog_clear_o(watchdog_clear),
    .reg_we_o(reg_we), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));
  // 4 ns clock
  initial begin
    forever #2 clk = ~clk;
  end
  // count one-cycle pulses towards the core
  always @(posedge clk) begin
    if (reg_we === 1'b1) we_cnt++;
    if (watchdog_clear === 1'b1) clr_cnt++;
  end
  // classic single cycle, held until ack is sampled high, then released
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat;
    `CHK(ack, 1'b1)
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // issue one instruction through the control word
  task automatic run(input mise_pkg::mise_op_t o, input logic dst, input logic [5:0] idx);
    bus(1'b1, mise_pkg::OFS_CTRL, 32'h8000_0000 | (32'(idx) << mise_pkg::CTRL_IDX_LSB)
      | (32'(dst) << mise_pkg::CTRL_DEST_BIT) | 32'(o));
  endtask
  // expected {zero, digit carry, carry, result} of a + ~b + ci
  function automatic logic [10:0] subf(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, a} + {1'b0, ~b} + 9'(ci);
    n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'(ci);
    return {s[7:0] == 8'h00, n[4], s[8], s[7:0]};
  endfunction
  // set operand, accumulator and status in one go
  task automatic setup(input logic [7:0] r, input logic [7:0] a, input logic [31:0] st);
    bus(1'b1, mise_pkg::OFS_OPND, {24'h00_0000, r});
    bus(1'b1, mise_pkg::OFS_ACCUM, {24'h00_0000, a});
    bus(1'b1, mise_pkg::OFS_STAT, st);
  endtask
  task automatic t_reset;
    bus(1'b0, mise_pkg::OFS_ACCUM, 32'h0);
    `CHK(rd, 32'h0000_0000)
    bus(1'b0, mise_pkg::OFS_STAT, 32'h0);
    `CHK(rd[6:0], 7'h18)
    bus(1'b0, 8'h1C, 32'h0);
    `CHK(rd, 32'h0000_0000)
    $display("test reset done");
  endtask
  task automatic t_imm;
    logic [7:0] ti [5] = '{8'h05, 8'h05, 8'h06, 8'h06, 8'h10};
    logic [7:0] ta [5] = '{8'h06, 8'h06, 8'h05, 8'h05, 8'h01};
    logic [10:0] e;
    for (int k = 0; k < 5; k++) begin
      e = subf(ti[k], ta[k], k[0]);
      setup(ti[k], ta[k], 32'(k[0]));
      run(mise_pkg::MISE_OP_SBCI, 1'b0, 6'h00);
      bus(1'b0, mise_pkg::OFS_ACCUM, 32'h0);
      `CHK(rd[7:0], e[7:0])
      bus(1'b0, mise_pkg::OFS_STAT, 32'h0);
      `CHK(rd[2:0], e[10:8])
    end
    $display("test immediate subtract done");
  endtask
  task automatic t_sub;
    logic [7:0] r;
    logic [7:0] a;
    logic [10:0] e;
    int n0;
    for (int d = 0; d < 2; d++) begin
      r = d ? 8'h06 : 8'h05;
      a = d ? 8'h05 : 8'h06;
      e = subf(r, a, 1'b1);
      setup(r, a, 32'h0);
      n0 = we_cnt;
      run(mise_pkg::MISE_OP_SUBR, d[0], 6'h3F);
      bus(1'b0, mise_pkg::OFS_ACCUM, 32'h0);
      `CHK(rd[7:0], d ? a : e[7:0])
      bus(1'b0, mise_pkg::OFS_STAT, 32'h0);
      `CHK(rd[2:0], e[10:8])
      `CHK(32'(we_cnt - n0), 32'(d))
      if (d) `CHK({reg_addr, reg_wdata}, {6'h3F, e[7:0]})
    end
    $display("test register subtract done");
  endtask
  task automatic t_swap;
    for (int d = 0; d < 2; d++) begin
      setup(8'hA5, 8'h3C, 32'h7);
      run(mise_pkg::MISE_OP_SWAP, d[0], 6'h00);
      bus(1'b0, mise_pkg::OFS_ACCUM, 32'h0);
      `CHK(rd[7:0], d ? 8'h3C : 8'h5A)
      if (d) `CHK(reg_wdata, 8'h5A)
      bus(1'b0, mise_pkg::OFS_STAT, 32'h0);
      `CHK(rd[2:0], 3'h7)
    end
    $display("test nibble swap done");
  endtask
  task automatic t_page;
    for (int k = 0; k < 16; k += 15) begin
      setup(8'h00, 8'h80 | 8'(k), 32'h7);
      run(mise_pkg::MISE_OP_PGWR, 1'b0, 6'(k));
      bus(1'b0, mise_pkg::OFS_ACCUM, 32'h0);
      `CHK(rd[7:0], 8'h80 | 8'(k))
    end
    for (int j = 0; j < 4; j++) begin
      bus(1'b1, mise_pkg::OFS_ACCUM, 32'h0);
      run(mise_pkg::MISE_OP_PGRD, 1'b0, 6'(j[0] ? 15 : 0));
      bus(1'b0, mise_pkg::OFS_ACCUM, 32'h0);
      `CHK(rd[7:0], 8'h80 | 8'(j[0] ? 15 : 0))
      bus(1'b0, mise_pkg::OFS_STAT, 32'h0);
      `CHK(rd[2:0], 3'h7)
    end
    $display("test page registers done");
  endtask
  task automatic t_halt;
    int n0;
    n0 = clr_cnt;
    run(mise_pkg::MISE_OP_HALT, 1'b0, 6'h00);
    `CHK(halt, 1'b1)
    bus(1'b0, mise_pkg::OFS_STAT, 32'h0);
    `CHK(32'(clr_cnt - n0), 32'h1)
    `CHK(rd[5:3], 3'b110)
    bus(1'b1, mise_pkg::OFS_STAT, 32'h0);
    `CHK(halt, 1'b0)
    $display("test halt done");
  endtask
  // verdict and end of run
  task automatic final_report;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_imm();
    t_sub();
    t_swap();
    t_page();
    t_halt();
    final_report();
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #40000;
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
